//--- core/mcu_instruction_decoder.sv
// Purpose: decodes and executes 14-bit instruction words, four clocks per instruction cycle
// Assumes: program memory answers one clock after the address, file memory in the same clock
// Notes:   two-cycle instructions run a second, flushed cycle as no-op
//
// Contract
// - destination bit picks working or file register
// - add literal to working, update C DC Z
// - bit clear in file register, flags kept
// - bit set in file register, flags kept
// - skip next when tested bit is zero
// - skip next when tested bit is one
// - decrement to destination, skip on zero
// - increment to destination, skip on zero
// - jumps and skips take two cycles
// - port self-modify reads pin levels
// - timer count write clears assigned prescaler
// - rotates go through carry, carry only
// - file logic ops update zero only
// - literal logic ops into working, zero only
// - literal minus working, update C DC Z
// - literal return loads working, plain return keeps it; both two cycles
// - standby in one cycle, sets status
// - each instruction is one 14-bit word
// - cycle spans four clocks, one or two per instruction
// - named file register always read first
// - watchdog clear sets timeout and powerdown
`timescale 1ns/1ns
module mcu_instruction_decoder #(
  parameter logic [6:0] TIMER_ADDR = 7'h01,
  parameter logic [6:0] PORT_ADDR = 7'h05
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  output logic [12:0] PM_ADDR,
  input wire logic [13:0] PM_DATA,
  output logic [6:0] FR_ADDR,
  input wire logic [7:0] FR_RDATA,
  output logic [7:0] FR_WDATA,
  output logic FR_WE,
  input wire logic [7:0] PIN_LEVELS,
  input wire logic [1:0] PAGE_SEL,
  input wire logic PRESCALER_ON_TIMER,
  output logic PRESCALE_CLR,
  output logic WDT_CLR,
  output logic STANDBY,
  output logic [7:0] WORK_REG,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // reset asserts at once but leaves through two flops
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------------
  mcu_core_pkg::core_state_t s_reg;
  mcu_core_pkg::core_state_t s_next;
  mcu_core_pkg::decode_t dec;
  mcu_core_pkg::alu_out_t alu;
  logic [13:0] ins;
  logic [2:0] bsel;
  logic adv;
  logic exec;
  logic skip;
  logic [12:0] pc_inc;

  assign ins = s_reg.instr; // one whole word per instruction
  assign bsel = ins[9:7];
  assign adv = s_reg.run && !s_reg.standby;
  assign exec = CE && adv && s_reg.phase == mcu_core_pkg::PH_EXEC &&
                !s_reg.flush;
  assign pc_inc = 13'(s_reg.pc + mcu_core_pkg::PC_STEP);

  // field decode; casez wildcards make don't-care bits harmless
  always_comb begin
    dec = '{op: mcu_core_pkg::ALU_PASS_A, default: 1'b0};
    case (ins[13:12])
      2'b00: begin
        dec.to_file = ins[7]; // d = 1 writes back to f
        dec.to_w = !ins[7]; // d = 0 writes working
        dec.upd_z = 1'b1;
        case (ins[11:8])
          4'h0: begin
            dec.upd_z = 1'b0;
            dec.to_w = 1'b0;
            dec.op = mcu_core_pkg::ALU_PASS_W;
            casez (ins[7:0])
              8'b1???_????: dec.to_file = 1'b1;
              8'h08, 8'h09: dec.ret = 1'b1;
              8'h63: dec.sleep = 1'b1;
              8'h64: dec.wdt = 1'b1;
              default: dec.to_file = 1'b0;
            endcase
          end
          4'h1: dec.op = mcu_core_pkg::ALU_ZERO;
          4'h2: begin
            dec.op = mcu_core_pkg::ALU_SUB;
            {dec.upd_c, dec.upd_dc} = 2'b11;
          end
          4'h3: dec.op = mcu_core_pkg::ALU_DEC;
          4'h4: dec.op = mcu_core_pkg::ALU_OR;
          4'h5: dec.op = mcu_core_pkg::ALU_AND;
          4'h6: dec.op = mcu_core_pkg::ALU_XOR;
          4'h7: begin
            dec.op = mcu_core_pkg::ALU_ADD;
            {dec.upd_c, dec.upd_dc} = 2'b11;
          end
          4'h9: dec.op = mcu_core_pkg::ALU_COM;
          4'hA: dec.op = mcu_core_pkg::ALU_INC;
          4'hB: begin
            dec.op = mcu_core_pkg::ALU_DEC;
            {dec.upd_z, dec.skip_zero} = 2'b01;
          end
          4'hC, 4'hD: begin
            dec.op = ins[8] ? mcu_core_pkg::ALU_RL : mcu_core_pkg::ALU_RR;
            {dec.upd_z, dec.upd_c} = 2'b01;
          end
          4'hE: dec.upd_z = 1'b0;
          4'hF: begin
            dec.op = mcu_core_pkg::ALU_INC;
            {dec.upd_z, dec.skip_zero} = 2'b01;
          end
          default: dec.op = mcu_core_pkg::ALU_PASS_A;
        endcase
        if (ins[11:8] == 4'hE) begin
          dec.op = mcu_core_pkg::ALU_SWAP;
        end
      end
      2'b01: begin
        case (ins[11:10])
          2'b00: begin
            dec.op = mcu_core_pkg::ALU_BCLR;
            dec.to_file = 1'b1;
          end
          2'b01: begin
            dec.op = mcu_core_pkg::ALU_BSET;
            dec.to_file = 1'b1;
          end
          2'b10: dec.btest = 1'b1;
          default: {dec.btest, dec.bwant} = 2'b11;
        endcase
      end
      2'b10: begin
        dec.jump = 1'b1;
        dec.call = !ins[11];
      end
      default: begin
        dec.lit = 1'b1;
        dec.to_w = 1'b1; // literal results land in working
        dec.upd_z = 1'b1;
        casez (ins[11:8])
          4'b00??: dec.upd_z = 1'b0;
          4'b01??: {dec.upd_z, dec.ret} = 2'b01;
          4'b1000: dec.op = mcu_core_pkg::ALU_OR;
          4'b1001: dec.op = mcu_core_pkg::ALU_AND;
          4'b1010: dec.op = mcu_core_pkg::ALU_XOR;
          4'b110?: begin
            dec.op = mcu_core_pkg::ALU_SUB;
            {dec.upd_c, dec.upd_dc} = 2'b11;
          end
          4'b111?: begin
            dec.op = mcu_core_pkg::ALU_ADD;
            {dec.upd_c, dec.upd_dc} = 2'b11;
          end
          default: dec.upd_z = 1'b0;
        endcase
      end
    endcase
  end

  // ------------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------------
  mcu_alu alu_i (
    .op(dec.op),
    .a(dec.lit ? ins[7:0] : s_reg.operand),
    .w(s_reg.w),
    .bit_sel(bsel),
    .cin(s_reg.c),
    .res(alu)
  );

  // skip on zero result or on the tested bit matching
  assign skip = (dec.skip_zero && alu.y == 8'h00) ||
                (dec.btest && s_reg.operand[bsel] == dec.bwant);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  // four phases per instruction: address, fetch, file read, execute
  always_comb begin
    s_next = s_reg;
    s_next.pin_meta = PIN_LEVELS;
    s_next.pin_sync = s_reg.pin_meta;
    s_next.fr_we = 1'b0;
    s_next.prescale_clr = 1'b0;
    s_next.wdt_clr = 1'b0;
    s_next.rdata = 8'h00;
    // register port; unmapped reads return zero
    if (REG_RD) begin
      case (REG_ADDR)
        mcu_core_pkg::REG_CTRL: s_next.rdata = {7'h00, s_reg.run};
        mcu_core_pkg::REG_WORK: s_next.rdata = s_reg.w;
        mcu_core_pkg::REG_STATUS:
          s_next.rdata = {2'b00, s_reg.standby, s_reg.to, s_reg.pd,
                          s_reg.z, s_reg.dc, s_reg.c};
        mcu_core_pkg::REG_PC_LO: s_next.rdata = s_reg.pc[7:0];
        mcu_core_pkg::REG_PC_HI: s_next.rdata = {3'b000, s_reg.pc[12:8]};
        default: s_next.rdata = 8'h00;
      endcase
    end
    // wake is applied first so a standby in the same cycle still wins
    if (REG_WR && REG_ADDR == mcu_core_pkg::REG_CTRL) begin
      s_next.run = REG_WDATA[mcu_core_pkg::CTRL_RUN_BIT];
      if (REG_WDATA[mcu_core_pkg::CTRL_WAKE_BIT]) begin
        s_next.standby = 1'b0;
      end
    end
    if (adv) begin
      case (s_reg.phase) // one state per oscillator period
        mcu_core_pkg::PH_ADDR: s_next.phase = mcu_core_pkg::PH_INSTR;
        mcu_core_pkg::PH_INSTR: begin
          s_next.instr = PM_DATA;
          s_next.fr_addr = PM_DATA[6:0];
          s_next.phase = mcu_core_pkg::PH_READ;
        end
        mcu_core_pkg::PH_READ: begin
          // always read first, even for pure writes
          // the port reads its pins, not the latch
          s_next.operand = (s_reg.fr_addr == PORT_ADDR) ? s_reg.pin_sync
                                                         : FR_RDATA;
          s_next.phase = mcu_core_pkg::PH_EXEC;
        end
        default: begin
          s_next.phase = mcu_core_pkg::PH_ADDR;
          s_next.flush = 1'b0; // second cycle ran as no-op
          if (!s_reg.flush) begin
            s_next.pc = pc_inc;
            if (dec.to_w) begin
              s_next.w = dec.ret && !dec.lit ? s_reg.w : alu.y;
            end
            if (dec.to_file) begin
              s_next.fr_we = 1'b1;
              s_next.fr_wdata = alu.y;
            end
            if (dec.upd_c) begin
              s_next.c = alu.c;
            end
            if (dec.upd_dc) begin
              s_next.dc = alu.dc;
            end
            if (dec.upd_z) begin
              s_next.z = alu.y == 8'h00;
            end
            // timer count rewrite restarts its prescaler
            if (dec.to_file && s_reg.fr_addr == TIMER_ADDR &&
                PRESCALER_ON_TIMER) begin
              s_next.prescale_clr = 1'b1;
            end
            // skipped word is stepped over and its slot flushed
            if (skip) begin
              s_next.pc = 13'(s_reg.pc + mcu_core_pkg::PC_SKIP_STEP);
              s_next.flush = 1'b1;
            end
            // page bits supply the top of the jump target
            if (dec.jump) begin
              s_next.pc = {PAGE_SEL, ins[10:0]};
              s_next.flush = 1'b1;
            end
            if (dec.call) begin
              s_next.stack[s_reg.sp] = pc_inc;
              s_next.sp = s_reg.sp + 1'b1;
            end
            if (dec.ret) begin
              s_next.pc = s_reg.stack[s_reg.sp - 1'b1];
              s_next.sp = s_reg.sp - 1'b1;
              s_next.flush = 1'b1;
            end
            if (dec.sleep) begin
              s_next.standby = 1'b1;
              {s_next.to, s_next.pd} = 2'b10;
            end
            if (dec.wdt) begin
              s_next.wdt_clr = 1'b1;
              {s_next.to, s_next.pd} = 2'b11;
            end
          end
          s_next.pm_addr = s_next.pc;
        end
      endcase
    end
  end

  // clock enable low freezes every field
  always_ff @(posedge CLOCK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      s_reg <= mcu_core_pkg::STATE_RESET;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // outputs come straight from the state register
  assign PM_ADDR = s_reg.pm_addr;
  assign FR_ADDR = s_reg.fr_addr;
  assign FR_WDATA = s_reg.fr_wdata;
  assign FR_WE = s_reg.fr_we;
  assign PRESCALE_CLR = s_reg.prescale_clr;
  assign WDT_CLR = s_reg.wdt_clr;
  assign STANDBY = s_reg.standby;
  assign WORK_REG = s_reg.w;
  assign REG_RDATA = s_reg.rdata;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_sync_reg);

  dest_work_a: assert property (
    exec && ins[13:12] == 2'b00 && ins[11:8] != 4'h0 && !ins[7]
    |=> !FR_WE && WORK_REG == $past(alu.y))
    else $error("d=0 result not routed to working register");

  add_literal_a: assert property (
    exec && ins[13:9] == 5'b11111
    |=> WORK_REG == 8'($past(s_reg.w) + $past(ins[7:0])))
    else $error("add literal sum wrong");

  bit_clear_a: assert property (
    exec && ins[13:11] == 3'b010
    |=> FR_WE && FR_WDATA[$past(bsel)] == $past(ins[10]) &&
        $stable({s_reg.c, s_reg.dc, s_reg.z}))
    else $error("bit clear or set result wrong");

  bit_skip_a: assert property (
    exec && ins[13:11] == 3'b011 &&
    s_reg.operand[bsel] == ins[10]
    |=> s_reg.flush && PM_ADDR == 13'($past(s_reg.pc) + 13'h0002))
    else $error("bit test skip not taken");

  zero_skip_a: assert property (
    exec && dec.skip_zero && alu.y == 8'h00
    |=> s_reg.flush && $stable({s_reg.c, s_reg.dc, s_reg.z}))
    else $error("zero skip missing or flags touched");

  flush_cycle_a: assert property (
    CE && adv && s_reg.flush && s_reg.phase == mcu_core_pkg::PH_EXEC
    |=> !FR_WE && !s_reg.flush && $stable(s_reg.w))
    else $error("flushed cycle did work");

  prescale_a: assert property (
    exec && dec.to_file && s_reg.fr_addr == TIMER_ADDR &&
    PRESCALER_ON_TIMER |=> PRESCALE_CLR && FR_WE)
    else $error("prescaler clear missing");

  rotate_a: assert property (
    exec && ins[13:9] == 5'b00110
    |=> s_reg.c == ($past(ins[8]) ? $past(s_reg.operand[7])
                                  : $past(s_reg.operand[0])) &&
        $stable(s_reg.z))
    else $error("rotate carry wrong");

  logic_flags_a: assert property (
    exec && dec.op inside {mcu_core_pkg::ALU_AND, mcu_core_pkg::ALU_OR,
                           mcu_core_pkg::ALU_XOR}
    |=> $stable({s_reg.c, s_reg.dc}) && s_reg.z == ($past(alu.y) == 8'h00))
    else $error("logic op flag update wrong");

  standby_a: assert property (
    exec && dec.sleep |=> STANDBY && s_reg.to && !s_reg.pd && !s_reg.flush)
    else $error("standby entry wrong");

  watchdog_a: assert property (
    exec && dec.wdt |=> WDT_CLR && s_reg.to && s_reg.pd ##1 !WDT_CLR)
    else $error("watchdog clear wrong");

endmodule : mcu_instruction_decoder

//--- core/mcu_core_pkg.sv
// Purpose: shared types and constants of the instruction decoder core
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes:   every offset, reset value and cycle count lives here
package mcu_core_pkg;

  // ------------------------------------------------------------------
  // widths and cycle counts
  // ------------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = $clog2(STACK_DEPTH);
  // oscillator periods per instruction cycle, one per phase state
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_STEP = 13'h0002;

  // ------------------------------------------------------------------
  // register port map
  // ------------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_WORK = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_PC_LO = 3'h3;
  localparam logic [2:0] REG_PC_HI = 3'h4;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00, PH_INSTR = 2'b01, PH_READ = 2'b10, PH_EXEC = 2'b11
  } phase_t;

  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0, ALU_PASS_W = 4'h1, ALU_ZERO = 4'h2, ALU_ADD = 4'h3,
    ALU_SUB = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7,
    ALU_COM = 4'h8, ALU_DEC = 4'h9, ALU_INC = 4'hA, ALU_RR = 4'hB,
    ALU_RL = 4'hC, ALU_SWAP = 4'hD, ALU_BCLR = 4'hE, ALU_BSET = 4'hF
  } alu_op_t;

  typedef struct packed {
    logic [7:0] y;
    logic c;
    logic dc;
  } alu_out_t;

  typedef struct packed {
    alu_op_t op;
    logic lit, to_file, to_w, upd_c, upd_dc, upd_z;
    logic skip_zero, btest, bwant, call, jump, ret, sleep, wdt;
  } decode_t;

  typedef struct packed {
    phase_t phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pm_addr;
    logic [INSTR_W-1:0] instr;
    logic [6:0] fr_addr;
    logic [7:0] operand;
    logic [7:0] w;
    logic c, dc, z, to, pd;
    logic flush, standby, run;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] fr_wdata;
    logic fr_we, prescale_clr, wdt_clr;
    logic [7:0] rdata;
  } core_state_t;

  // after reset: running, timeout and powerdown flags high, rest zero
  localparam core_state_t STATE_RESET = '{phase: PH_ADDR, to: 1'b1,
                                          pd: 1'b1, run: 1'b1,
                                          default: '0};

endpackage : mcu_core_pkg

//--- core/mcu_alu.sv
// Purpose: 8-bit arithmetic and logic unit of the core
// Assumes: purely combinational, operands already selected
// Notes:   subtraction is a minus w, carry set means no borrow
`timescale 1ns/1ns
module mcu_alu (
  input wire mcu_core_pkg::alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] w,
  input wire logic [2:0] bit_sel,
  input wire logic cin,
  output mcu_core_pkg::alu_out_t res
);

  // ------------------------------------------------------------------
  // adder shared by add and subtract
  // ------------------------------------------------------------------
  // returns {digit carry, carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] x,
                                      input logic [7:0] y,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    full = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    add8 = {lo[4], full};
  endfunction : add8

  // ------------------------------------------------------------------
  // operation select
  // ------------------------------------------------------------------
  // carry and digit carry only meaningful for add, sub and rotates
  always_comb begin
    logic [9:0] sum;
    sum = 10'h000;
    res = '{y: a, c: cin, dc: 1'b0};
    case (op)
      mcu_core_pkg::ALU_PASS_A: res.y = a;
      mcu_core_pkg::ALU_PASS_W: res.y = w;
      mcu_core_pkg::ALU_ZERO: res.y = 8'h00;
      mcu_core_pkg::ALU_ADD: begin
        sum = add8(a, w, 1'b0);
        res = '{y: sum[7:0], c: sum[8], dc: sum[9]};
      end
      mcu_core_pkg::ALU_SUB: begin
        sum = add8(a, ~w, 1'b1);
        res = '{y: sum[7:0], c: sum[8], dc: sum[9]};
      end
      mcu_core_pkg::ALU_AND: res.y = a & w;
      mcu_core_pkg::ALU_OR: res.y = a | w;
      mcu_core_pkg::ALU_XOR: res.y = a ^ w;
      mcu_core_pkg::ALU_COM: res.y = ~a;
      mcu_core_pkg::ALU_DEC: res.y = 8'(a - 8'h01);
      mcu_core_pkg::ALU_INC: res.y = 8'(a + 8'h01);
      mcu_core_pkg::ALU_RR: res = '{y: {cin, a[7:1]}, c: a[0], dc: 1'b0};
      mcu_core_pkg::ALU_RL: res = '{y: {a[6:0], cin}, c: a[7], dc: 1'b0};
      mcu_core_pkg::ALU_SWAP: res.y = {a[3:0], a[7:4]};
      mcu_core_pkg::ALU_BCLR: res.y = a & ~(8'h01 << bit_sel);
      mcu_core_pkg::ALU_BSET: res.y = a | (8'h01 << bit_sel);
      default: res.y = a;
    endcase
  end

endmodule : mcu_alu

//--- testbench/prog_file_mem.sv
// Purpose: program and file memory on the far side of the decoder
// Assumes: program words are registered, file reads flow straight through
// Notes:   the bench loads contents just before it resets the core
`timescale 1ns/1ns
module prog_file_mem (
  input wire logic clock,
  input wire logic [12:0] pm_addr,
  output logic [13:0] pm_data,
  input wire logic [6:0] fr_addr,
  output logic [7:0] fr_rdata,
  input wire logic [7:0] fr_wdata,
  input wire logic fr_we
);
  logic [13:0] prog [0:255];
  logic [7:0] regs [0:127];
  // ----------------------------------------------------------------
  // registered program answers
  // ----------------------------------------------------------------
  // one clock of latency; small programs only, so the address is cut
  always @(posedge clock) begin
    pm_data <= prog[pm_addr[7:0]];
    if (fr_we) begin
      regs[fr_addr] <= fr_wdata;
    end
  end
  // the core samples file data one clock after it moves the address,
  // so a registered read here would hand it the previous register
  assign fr_rdata = regs[fr_addr];
endmodule : prog_file_mem

//--- testbench/mcu_instruction_decoder_test.sv
// Purpose: runs short programs through the decoder and checks results
// Assumes: default timer and port addresses of the core
// Notes:   each program ends in a jump to itself, so it can run long
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD at %0t: got %h, expected %h", $time, (a), (e)); end end
module mcu_instruction_decoder_test;
  logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, pre_on = 1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, v;
  logic [12:0] pm_addr;
  logic [13:0] pm_data;
  logic [6:0] fr_addr;
  logic [7:0] fr_rdata, fr_wdata, work, reg_rdata;
  logic fr_we, pre_clr, wdt_clr, standby;
  int err_count = 0, num_checks = 0, wdt_n = 0, pre_n = 0;
  logic [13:0] pq [$];

  mcu_instruction_decoder mcu_instruction_decoder_inst (
    .CLOCK(clock), .RESETN(resetn), .CE(1'b1), .PM_ADDR(pm_addr),
    .PM_DATA(pm_data), .FR_ADDR(fr_addr), .FR_RDATA(fr_rdata),
    .FR_WDATA(fr_wdata), .FR_WE(fr_we), .PIN_LEVELS(8'hA5),
    .PAGE_SEL(2'h0), .PRESCALER_ON_TIMER(pre_on), .PRESCALE_CLR(pre_clr),
    .WDT_CLR(wdt_clr), .STANDBY(standby), .WORK_REG(work),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
  prog_file_mem prog_file_mem_inst (
    .clock(clock), .pm_addr(pm_addr), .pm_data(pm_data),
    .fr_addr(fr_addr), .fr_rdata(fr_rdata), .fr_wdata(fr_wdata),
    .fr_we(fr_we));

  // ----------------------------------------------------------------
  // clock and pulse counters
  // ----------------------------------------------------------------
  initial begin
    forever #50 clock = ~clock;
  end
  // pulses are one clock long, so each edge counts at most one
  // cleared by reset, so no task races the counting edge
  always @(posedge clock) begin
    if (!resetn) begin
      wdt_n <= 0;
      pre_n <= 0;
    end else begin
      wdt_n <= wdt_n + (wdt_clr === 1'b1);
      pre_n <= pre_n + (pre_clr === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // register port and program tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // load the program, reset the core, let it reach its final loop
  task automatic run();
    for (int i = 0; i < 256; i++) begin
      prog_file_mem_inst.prog[i] = (i < pq.size()) ? pq[i] : 14'h0000;
    end
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (300) @(posedge clock);
  endtask : run
  task automatic check_ws(input string name, input logic [7:0] ew, es);
    logic [7:0] d;
    rd(3'h1, d);
    `CHK(d, ew)
    `CHK(work, ew)
    rd(3'h2, d);
    `CHK(d, es)
    $display("test %s done", name);
  endtask : check_ws
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // programs
  // ----------------------------------------------------------------
  initial begin
    // add literal with a spare bit set, then a literal xor
    pq = '{14'h30F8, 14'h3F08, 14'h3A5A, 14'h2803};
    run();
    check_ws("add", 8'h5A, 8'h1B);
    pq = '{14'h3003, 14'h3C05, 14'h390D, 14'h2803};
    run();
    check_ws("sub", 8'h00, 8'h1F);
    // rotates, file logic and bit ops on one file register
    pq = '{14'h3081, 14'h00A0, 14'h0DA0, 14'h0C20, 14'h04A0, 14'h13A0,
           14'h1620, 14'h0620, 14'h2808};
    run();
    `CHK(prog_file_mem_inst.regs[32], 8'h13)
    check_ws("file", 8'h92, 8'h18);
    // skipped words would load w with a marker value
    pq = '{14'h3001, 14'h00A1, 14'h0BA1, 14'h30EE, 14'h0F21, 14'h1C21,
           14'h3E10, 14'h1821, 14'h3077, 14'h2809};
    run();
    `CHK(prog_file_mem_inst.regs[33], 8'h00)
    check_ws("skip", 8'h11, 8'h18);
    // call and return, then standby; a wake write ends standby
    pq = '{14'h0064, 14'h2004, 14'h0063, 14'h2803, 14'h343C};
    run();
    `CHK(wdt_n, 1)
    `CHK(standby, 1'b1)
    check_ws("call", 8'h3C, 8'h30);
    // working register is read only; unmapped offsets read zero
    wr(3'h1, 8'h00);
    rd(3'h5, v);
    `CHK(v, 8'h00)
    `CHK(work, 8'h3C)
    wr(3'h0, 8'h03);
    repeat (4) @(posedge clock);
    `CHK(standby, 1'b0)
    // port written from pins; timer ored into w with d clear, then written with d set
    prog_file_mem_inst.regs[5] = 8'hFF;
    prog_file_mem_inst.regs[1] = 8'h00;
    pq = '{14'h3000, 14'h0485, 14'h0401, 14'h0481, 14'h2804};
    run();
    `CHK(prog_file_mem_inst.regs[5], 8'hA5)
    `CHK(pre_n, 1)
    check_ws("port", 8'h00, 8'h1C);
    // same program with the prescaler not given to the timer
    @(posedge clock);
    pre_on <= 1'b0;
    run();
    `CHK(pre_n, 0)
    $display("test prescaler done");
    end_of_test();
  end
endmodule : mcu_instruction_decoder_test
